// >>> acs_sequencer.sv
// conversion sequencer: sample timing, accumulation, result and bias registers
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
#(
	parameter int DIV_RATIO_0 = 4,
	parameter int DIV_RATIO_1 = 8,
	parameter int DIV_RATIO_2 = 32,
	parameter int DIV_RATIO_3 = 31250
)
(
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic [2:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output var  logic [7:0] regRdData,
	input  wire logic       modulatorBit,
	output var  logic       sampleStrobe,
	output var  logic       offsetPolarity,
	output var  logic       adcPowerOn,
	output var  logic       ampPowerOn,
	output var  logic [1:0] converterBiasSelect,
	output var  logic [1:0] amplifierBiasSelect,
	output var  logic       conversionBusy,
	output var  logic       conversionDone
);

	acs_pkg::acs_state_type state_q;
	logic        [7:0]  cfg0_q;
	logic        [7:0]  cfg1_q;
	logic               contMode_q;
	logic        [15:0] divCnt_q;
	logic        [15:0] divLimit;
	logic               sampleTick;
	logic               modSync1_q;
	logic               modSync2_q;
	logic        [10:0] periodCnt_q;
	logic        [3:0]  elemCnt_q;
	logic signed [15:0] accum_q;
	logic        [15:0] result_q;
	logic               done_q;
	logic               doneFlag_q;
	logic               startReq;
	logic               lastTick;
	logic        [2:0]  osrSel;
	logic        [1:0]  nelcSel;
	logic        [10:0] osrRatio;
	logic        [3:0]  nelcCount;
	logic        [7:0]  rdMux;

	acs_fmt_if fmtBus ();

	acs_formatter u_formatter
	(
		.fmt (fmtBus.fmt)
	);

	// settings are used live; changing them mid-conversion corrupts that result
	assign osrSel     = cfg0_q[acs_pkg::CFG0_OSR_LSB +: 3];
	assign nelcSel    = cfg0_q[acs_pkg::CFG0_NELC_LSB +: 2];
	assign osrRatio   = acs_pkg::OSR_BASE << osrSel;
	assign nelcCount  = 4'h1 << nelcSel;
	assign startReq   = regWrite && regAddr == acs_pkg::REG_CTRL
		&& (regWrData[acs_pkg::CTRL_START] || regWrData[acs_pkg::CTRL_ALT]);
	assign lastTick   = state_q == acs_pkg::ST_QUANT && sampleTick;
	assign fmtBus.sum     = accum_q;
	assign fmtBus.osrSel  = osrSel;
	assign fmtBus.nelcSel = nelcSel;

	// outputs straight from registers, except busy, which is decoded from the state
	assign converterBiasSelect = cfg1_q[acs_pkg::CFG1_CBIAS_LSB +: 2];
	assign amplifierBiasSelect = cfg1_q[acs_pkg::CFG1_ABIAS_LSB +: 2];
	assign adcPowerOn          = cfg1_q[acs_pkg::CFG1_ADC_ON];
	assign ampPowerOn          = cfg1_q[acs_pkg::CFG1_AMP_ON];
	assign conversionBusy      = state_q != acs_pkg::ST_IDLE;
	assign conversionDone      = done_q;

	// software-written configuration
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cfg0_q     <= acs_pkg::CFG0_RST;
			cfg1_q     <= acs_pkg::CFG1_RST;
			contMode_q <= 1'b0;
		end
		else if (regWrite)
		begin
			case (regAddr)
				acs_pkg::REG_CTRL: contMode_q <= regWrData[acs_pkg::CTRL_CONT];
				acs_pkg::REG_CFG0: cfg0_q     <= regWrData;
				acs_pkg::REG_CFG1: cfg1_q     <= regWrData;
				default: ;
			endcase
		end
	end

	// sample-rate divider; the rate limit per bias setting is software's duty
	always_comb
	begin
		case (cfg0_q[acs_pkg::CFG0_RATE_LSB +: 2])
			2'b00:   divLimit = 16'(DIV_RATIO_0 - 1);
			2'b01:   divLimit = 16'(DIV_RATIO_1 - 1);
			2'b10:   divLimit = 16'(DIV_RATIO_2 - 1);
			default: divLimit = 16'(DIV_RATIO_3 - 1);
		endcase
	end

	assign sampleTick = divCnt_q >= divLimit; // >= so a lowered ratio cannot overrun

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			divCnt_q     <= 16'h0000;
			sampleStrobe <= 1'b0;
		end
		else
		begin
			divCnt_q     <= sampleTick ? 16'h0000 : divCnt_q + 16'h0001;
			sampleStrobe <= sampleTick;
		end
	end

	// modulator decision arrives from the analog side
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			modSync1_q <= 1'b0;
			modSync2_q <= 1'b0;
		end
		else
		begin
			modSync1_q <= modulatorBit;
			modSync2_q <= modSync1_q;
		end
	end

	// sequence: elementary conversions of osr+1 periods, then one quantization period
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q     <= acs_pkg::ST_IDLE;
			periodCnt_q <= 11'h000;
			elemCnt_q   <= 4'h0;
		end
		else if (startReq)
		begin
			state_q     <= acs_pkg::ST_ELEM;
			periodCnt_q <= 11'h000;
			elemCnt_q   <= 4'h0;
		end
		else
		begin
			case (state_q)
				acs_pkg::ST_ELEM:
					if (sampleTick)
					begin
						if (periodCnt_q == osrRatio)
						begin
							periodCnt_q <= 11'h000;
							if (elemCnt_q == nelcCount - 4'h1)
							begin
								state_q   <= acs_pkg::ST_QUANT;
								elemCnt_q <= 4'h0;
							end
							else
								elemCnt_q <= elemCnt_q + 4'h1;
						end
						else
							periodCnt_q <= periodCnt_q + 11'h001;
					end
				acs_pkg::ST_QUANT:
					if (sampleTick)
						state_q <= contMode_q ? acs_pkg::ST_ELEM : acs_pkg::ST_IDLE;
				acs_pkg::ST_IDLE: ;
				default: state_q <= acs_pkg::ST_IDLE;
			endcase
		end
	end

	// offset polarity flips at each elementary boundary so the offset cancels
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			offsetPolarity <= 1'b0;
		else if (startReq || lastTick)
			offsetPolarity <= 1'b0;
		else if (state_q == acs_pkg::ST_ELEM && sampleTick && periodCnt_q == osrRatio)
			offsetPolarity <= ~offsetPolarity;
	end

	// the sum over all elementary conversions; the scaling divides it into the mean
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			accum_q <= 16'sh0000;
		else if (startReq || lastTick)
			accum_q <= 16'sh0000;
		else if (state_q == acs_pkg::ST_ELEM && sampleTick)
			accum_q <= modSync2_q ? accum_q + 16'sh0001 : accum_q - 16'sh0001;
	end

	// both bytes load in one edge, done pulses from that same edge
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			result_q <= 16'h0000;
			done_q   <= 1'b0;
		end
		else
		begin
			done_q <= lastTick;
			if (lastTick)
				result_q <= fmtBus.code;
		end
	end

	// sticky done flag, cleared by a status read; a new completion wins
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			doneFlag_q <= 1'b0;
		else if (done_q)
			doneFlag_q <= 1'b1;
		else if (regRead && regAddr == acs_pkg::REG_STATUS)
			doneFlag_q <= 1'b0;
	end

	// read mux; unmapped addresses and write-only pulse bits read zero
	always_comb
	begin
		case (regAddr)
			acs_pkg::REG_CTRL:     rdMux = {5'h00, contMode_q, 2'b00};
			acs_pkg::REG_CFG0:     rdMux = cfg0_q;
			acs_pkg::REG_CFG1:     rdMux = cfg1_q;
			acs_pkg::REG_RES_HIGH: rdMux = result_q[15:8];
			acs_pkg::REG_RES_LOW:  rdMux = result_q[7:0];
			acs_pkg::REG_STATUS:   rdMux = {6'h00, doneFlag_q, conversionBusy};
			default:               rdMux = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			regRdData <= 8'h00;
		else
			regRdData <= regRead ? rdMux : 8'h00;
	end

	// helper: sample periods since the conversion began
	logic [13:0] convTicks_q;
	logic [13:0] totalPeriods;
	assign totalPeriods = 14'(nelcCount) * 14'(osrRatio + 11'h001) + 14'h0001;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			convTicks_q <= 14'h0000;
		else if (startReq || lastTick)
			convTicks_q <= 14'h0000;
		else if (conversionBusy && sampleTick)
			convTicks_q <= convTicks_q + 14'h0001;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_conv_length: assert property (lastTick && !startReq |-> convTicks_q + 14'h0001 == totalPeriods)
		else $error("conversion length does not match the period count");
	a_cont_restart: assert property (lastTick && contMode_q && !startReq |=> state_q == acs_pkg::ST_ELEM)
		else $error("continuous mode did not restart");
	a_zero_code: assert property (accum_q == 16'sh0000 |-> (fmtBus.code & ~fmtBus.forceMask) == 16'h0000)
		else $error("zero sum does not give zero code");
	a_sat_sign: assert property (accum_q > 16'sh0000 |-> !fmtBus.code[15])
		else $error("positive sum produced a negative code");
	a_force_bits: assert property (lastTick |=> (result_q & fmtBus.forceMask) == (fmtBus.forceMask ^ (fmtBus.forceMask >> 1)))
		else $error("forced low bits wrong");
	a_bias_write: assert property (regWrite && regAddr == acs_pkg::REG_CFG1 |=> converterBiasSelect == $past(regWrData[1:0]) && amplifierBiasSelect == $past(regWrData[3:2]))
		else $error("bias select did not follow write");
	a_power_off: assert property (regWrite && regAddr == acs_pkg::REG_CFG1 && !regWrData[acs_pkg::CFG1_ADC_ON] |=> !adcPowerOn ##1 !adcPowerOn || $past(regWrite))
		else $error("converter not switched off");
	a_start_trig: assert property (startReq |=> state_q == acs_pkg::ST_ELEM && periodCnt_q == 11'h000 && accum_q == 16'sh0000)
		else $error("trigger did not start a conversion");
	a_period_bound: assert property (state_q == acs_pkg::ST_ELEM |-> periodCnt_q <= osrRatio)
		else $error("period count beyond oversampling ratio");
	a_elem_count: assert property (state_q == acs_pkg::ST_ELEM ##1 state_q == acs_pkg::ST_QUANT |-> $past(elemCnt_q) == nelcCount - 4'h1)
		else $error("wrong number of elementary conversions");
	a_polarity_flip: assert property (state_q == acs_pkg::ST_ELEM && sampleTick && periodCnt_q == osrRatio && !startReq |=> offsetPolarity != $past(offsetPolarity))
		else $error("offset polarity did not alternate");
	a_both_bytes: assert property (lastTick |=> done_q && result_q == $past(fmtBus.code))
		else $error("result bytes not loaded with done");

	c_single_conv: cover property (startReq ##[1:300] conversionDone);
	c_continuous: cover property (conversionDone && contMode_q ##1 conversionBusy);
	c_saturated: cover property (lastTick && fmtBus.code == acs_pkg::CODE_MAX);
	c_restart_busy: cover property (conversionBusy && startReq);

endmodule : acs_sequencer
`default_nettype wire

// >>> acs_pkg.sv
// constants, register map and types for the conversion sequencer
package acs_pkg;

	// register indices on the 3-bit register port
	localparam logic [2:0] REG_CTRL     = 3'h0;
	localparam logic [2:0] REG_CFG0     = 3'h1;
	localparam logic [2:0] REG_CFG1     = 3'h2;
	localparam logic [2:0] REG_RES_HIGH = 3'h3;
	localparam logic [2:0] REG_RES_LOW  = 3'h4;
	localparam logic [2:0] REG_STATUS   = 3'h5;

	// control register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_ALT   = 1;
	localparam int CTRL_CONT  = 2;

	// configuration fields
	localparam int CFG0_RATE_LSB  = 0;
	localparam int CFG0_OSR_LSB   = 2;
	localparam int CFG0_NELC_LSB  = 5;
	localparam int CFG1_CBIAS_LSB = 0;
	localparam int CFG1_ABIAS_LSB = 2;
	localparam int CFG1_ADC_ON    = 4;
	localparam int CFG1_AMP_ON    = 5;

	// status fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;

	// values after reset
	localparam logic [7:0] CFG0_RST = 8'h00;
	localparam logic [7:0] CFG1_RST = 8'h0F;

	// oversampling ratio base is 2^3 = 8
	localparam logic [10:0] OSR_BASE = 11'h008;
	// left shift that maps the raw sum onto a 16-bit code at osr=8, one elementary
	localparam logic [3:0] SHIFT_BASE = 4'hC;
	localparam logic signed [31:0] SAT_HI = 32'sh0000_7FFF;
	localparam logic signed [31:0] SAT_LO = 32'shFFFF_8000;
	localparam logic [15:0] CODE_MAX = 16'h7FFF;
	localparam logic [15:0] CODE_MIN = 16'h8000;

	// forced low-bit field length, 4 bits per {osr, nelc} entry, entry 0 lowest
	localparam logic [127:0] FORCE_TABLE = 128'h0000_0000_0000_0012_1234_3456_5677_7789;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_ELEM  = 3'h2,
		ST_QUANT = 3'h4
	} acs_state_type;

endpackage : acs_pkg

// >>> acs_fmt_if.sv
// carrier between the sequencer and the result formatter
`timescale 1ns/1ps
`default_nettype none
interface acs_fmt_if;
	logic signed [15:0] sum;
	logic        [2:0]  osrSel;
	logic        [1:0]  nelcSel;
	logic        [15:0] code;
	logic        [15:0] forceMask;

	modport seq (output sum, output osrSel, output nelcSel, input code, input forceMask);
	modport fmt (input sum, input osrSel, input nelcSel, output code, output forceMask);
endinterface : acs_fmt_if
`default_nettype wire

// >>> acs_formatter.sv
// scaling, saturation and low-bit forcing of the accumulated sum
`timescale 1ns/1ps
`default_nettype none
module acs_formatter
(
	acs_fmt_if.fmt fmt
);

	// scale to 16 bits, clamp, then force non-significant bits
	always_comb
	begin
		logic signed [31:0] wide;
		logic        [3:0]  shAmt;
		logic        [3:0]  len;
		logic        [15:0] clamp;
		wide  = 32'sh0000_0000;
		clamp = 16'h0000;
		len   = 4'h0;
		shAmt = 4'(fmt.osrSel) + 4'(fmt.nelcSel);
		wide  = 32'(fmt.sum);
		if (shAmt <= acs_pkg::SHIFT_BASE)
			wide = wide <<< (acs_pkg::SHIFT_BASE - shAmt);
		else
			wide = wide >>> (shAmt - acs_pkg::SHIFT_BASE);
		// positive and negative overflow pin to the extreme codes
		if (wide > acs_pkg::SAT_HI)
			clamp = acs_pkg::CODE_MAX;
		else if (wide < acs_pkg::SAT_LO)
			clamp = acs_pkg::CODE_MIN;
		else
			clamp = wide[15:0];
		len = acs_pkg::FORCE_TABLE[{fmt.osrSel, fmt.nelcSel, 2'b00} +: 4];
		fmt.forceMask = (16'h0001 << len) - 16'h0001;
		// pattern is a one in the top forced bit, zeros below it
		fmt.code = (clamp & ~fmt.forceMask) | (fmt.forceMask ^ (fmt.forceMask >> 1));
	end

endmodule : acs_formatter
`default_nettype wire

// >>> acs_frontend_model.sv
// behavioural analog front end that feeds modulator decisions to the sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_frontend_model
(
	input  wire logic clock,
	input  wire logic powered,
	input  wire logic level,
	output var  logic modulatorBit
);
	initial modulatorBit = 1'b0;

	// a full-scale input gives a constant decision stream; an unpowered chain
	// gives garbage, so a missed power-up shows as a wrong code
	always @(posedge clock)
	begin
		if (powered)
			modulatorBit <= level;
		else
			modulatorBit <= ~modulatorBit;
	end
endmodule : acs_frontend_model
`default_nettype wire

// >>> adc_conversion_sequencer_bench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_bench;
	logic        clock, rst_b, regWrite, regRead, level, conversionBusy, conversionDone;
	logic [2:0]  regAddr;
	logic [7:0]  regWrData, regRdData, d;
	logic        modulatorBit, sampleStrobe, offsetPolarity, adcPowerOn, ampPowerOn;
	logic [1:0]  converterBiasSelect, amplifierBiasSelect;
	logic        readLate = 1'b0;
	logic [31:0] lfsr;
	logic [7:0]  expQ[$];
	int          tickCount = 0;
	int          flips = 0;
	logic        polPrev = 1'b0;
	int          failCount = 0;
	int          checksDone = 0;
	int          i, j, t0;
	// forced low-bit field length, one nibble per {osr, nelc}, entry 0 lowest
	localparam logic [79:0] FORCE_LEN = 80'h0012_1234_3456_5677_7789;

	// all dividers short so the longest conversion stays a few thousand clocks
	acs_sequencer #(.DIV_RATIO_0(4), .DIV_RATIO_1(4), .DIV_RATIO_2(4), .DIV_RATIO_3(4)) uut
	(
		.clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.modulatorBit(modulatorBit), .sampleStrobe(sampleStrobe),
		.offsetPolarity(offsetPolarity), .adcPowerOn(adcPowerOn), .ampPowerOn(ampPowerOn),
		.converterBiasSelect(converterBiasSelect), .amplifierBiasSelect(amplifierBiasSelect),
		.conversionBusy(conversionBusy), .conversionDone(conversionDone)
	);

	acs_frontend_model front
	(
		.clock(clock), .powered(adcPowerOn & ampPowerOn), .level(level),
		.modulatorBit(modulatorBit)
	);

	always #2 clock = ~clock;

	function automatic logic [31:0] lfsrNext(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsrNext

	task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
		checksDone++;
		if (got !== want)
		begin
			failCount++;
			$display("BAD %0t %s got %h want %h", $time, what, got, want);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	task automatic idle(input int n);
		regWrite <= 1'b0;
		regRead <= 1'b0;
		repeat (n) @(posedge clock);
	endtask : idle

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		regAddr <= a;
		regWrData <= v;
		regWrite <= 1'b1;
		regRead <= 1'b0;
		@(posedge clock);
	endtask : wr

	task automatic rd(input logic [2:0] a, input logic [7:0] v);
		expQ.push_back(v);
		regAddr <= a;
		regRead <= 1'b1;
		regWrite <= 1'b0;
		@(posedge clock);
	endtask : rd

	task automatic waitDone();
		int n;
		n = 0;
		idle(1);
		while (conversionDone !== 1'b1 && n < 40000)
		begin
			@(posedge clock);
			n++;
		end
		check({15'h0000, conversionDone}, 16'h0001, "done seen");
	endtask : waitDone

	// full-scale input, so the code is a clamped extreme, low bits forced where the table length is nonzero
	task automatic conv(input logic [2:0] osr, input logic [1:0] nelc, input logic pol,
		input logic alt);
		int fl;
		int f0;
		logic [15:0] code;
		fl = (osr < 3'h5) ? int'(FORCE_LEN[(int'(osr) * 4 + int'(nelc)) * 4 +: 4]) : 0;
		code = pol ? 16'h7FFF : 16'h8000;
		code = (code >> fl) << fl;
		if (fl > 0)
			code[fl - 1] = 1'b1;
		level <= pol;
		wr(acs_pkg::REG_CFG0, {1'b0, nelc, osr, lfsr[3:2]});
		idle(4);
		wr(acs_pkg::REG_CTRL, alt ? 8'h02 : 8'h01);
		idle(1);
		check({15'h0000, conversionBusy}, 16'h0001, "busy after start");
		check({15'h0000, offsetPolarity}, 16'h0000, "polarity at start");
		// a tick on the start edge itself is not part of the conversion
		idle(1);
		t0 = tickCount;
		f0 = flips;
		waitDone();
		check({15'h0000, offsetPolarity}, 16'h0000, "polarity cleared at end");
		idle(1);
		check({14'h0000, conversionDone, conversionBusy}, 16'h0000, "after end");
		check(16'(flips - f0), 16'((1 << nelc) + int'(nelc == 2'h0)), "polarity toggles");
		check(16'(tickCount - t0), 16'((1 << nelc) * ((8 << osr) + 1) + 1), "ticks");
		rd(acs_pkg::REG_RES_HIGH, code[15:8]);
		rd(acs_pkg::REG_RES_LOW, code[7:0]);
		rd(acs_pkg::REG_STATUS, 8'h02);
		rd(acs_pkg::REG_STATUS, 8'h00);
	endtask : conv

	// count sample ticks and compare read data with the oldest note
	always @(posedge clock)
	begin
		tickCount <= tickCount + int'(sampleStrobe === 1'b1);
		flips <= flips + int'(offsetPolarity !== polPrev); // one per elementary, plus the clear when only one elementary runs
		polPrev <= offsetPolarity;
		readLate <= regRead;
		if (readLate === 1'b1 && expQ.size() > 0)
			check({8'h00, regRdData}, {8'h00, expQ.pop_front()}, "read data");
	end

	// bound on the whole run, well above the full conversion sweep
	initial
	begin
		#200000;
		failCount++;
		$display("BAD %0t watchdog expired", $time);
		print_verdict();
	end

	// main sequence
	initial
	begin
		clock = 1'b0;
		rst_b = 1'b0;
		regAddr = 3'h0;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		level = 1'b0;
		lfsr = 32'h4A01;
		repeat (10) @(posedge clock);
		check({10'h000, ampPowerOn, adcPowerOn, amplifierBiasSelect, converterBiasSelect},
			16'h000F, "reset outputs");
		rst_b <= 1'b1;
		@(posedge clock);
		rd(acs_pkg::REG_CFG1, 8'h0F);
		rd(3'h7, 8'h00);
		wr(acs_pkg::REG_STATUS, 8'hFF);
		rd(acs_pkg::REG_STATUS, 8'h00);
		$display("test registers ended");
		for (i = 0; i < 4; i++)
		begin
			lfsr = lfsrNext(lfsr);
			d = {2'b00, lfsr[1:0], i[1:0], ~i[1:0]};
			wr(acs_pkg::REG_CFG1, d);
			idle(2);
			check({10'h000, ampPowerOn, adcPowerOn, amplifierBiasSelect, converterBiasSelect},
				{8'h00, d}, "bias and power");
			rd(acs_pkg::REG_CFG1, d);
		end
		$display("test bias ended");
		wr(acs_pkg::REG_CFG1, 8'h3F); // full bias allows any rate
		for (i = 0; i < 6; i++)
			for (j = 0; j < 4; j++)
			begin
				lfsr = lfsrNext(lfsr);
				conv(i[2:0], j[1:0], lfsr[0], lfsr[1]);
			end
		$display("test conversions ended");
		wr(acs_pkg::REG_CFG0, 8'h00);
		wr(acs_pkg::REG_CTRL, 8'h05);
		rd(acs_pkg::REG_CTRL, 8'h04);
		waitDone();
		idle(1);
		t0 = tickCount;
		waitDone();
		idle(1);
		check(16'(tickCount - t0), 16'h000A, "back to back ticks");
		wr(acs_pkg::REG_CTRL, 8'h00);
		waitDone();
		idle(4);
		check({15'h0000, conversionBusy}, 16'h0000, "idle after stop");
		$display("test continuous ended");
		print_verdict();
	end
endmodule : adc_conversion_sequencer_bench
`default_nettype wire
